// ===== tb/gdc_gen_model.sv
// Behavioural generator on the SPI link that stores and returns channel settings.
`timescale 1ns/1ns
module gdc_gen_model (
    // SPI pins from the controller.
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_mosi,
    output logic o_miso
);
    // Shift register, reply word and per-channel settings.
    logic [47:0] rx;
    logic [31:0] rep;
    logic [15:0] gate_mem [64];
    logic [15:0] dly_mem [64];
    logic [15:0] last_code;
    int cnt;
    int frames;
    initial
    begin
        cnt = 0;
        frames = 0;
        o_miso = 1'b0;
        last_code = 16'h0000;
        foreach (gate_mem[k])
        begin
            gate_mem[k] = 16'h0000;
            dly_mem[k] = 16'h0000;
        end
    end
    // A new frame restarts the bit count.
    always @(negedge i_cs_n)
    begin
        cnt = 0;
        rx = 48'h0000_0000_0000;
    end
    always @(posedge i_sclk)
    begin
        if (!i_cs_n)
        begin
            rx = {rx[46:0], i_mosi};
            cnt++;
            // The code is known after 16 bits, so the reply can follow in the same frame.
            if (cnt == 16)
                rep = rx[15:12] == 4'h2 ? {~gate_mem[rx[5:0]], gate_mem[rx[5:0]]} :
                      rx[15:12] == 4'h3 ? {~dly_mem[rx[5:0]], dly_mem[rx[5:0]]} : 32'h0;
        end
    end
    // Reply in the last 32 bits.
    always @(negedge i_sclk)
    begin
        if (!i_cs_n && cnt >= 16 && cnt < 48)
            o_miso = rep[47-cnt];
    end
    always @(posedge i_cs_n)
    begin
        // Released line shows the inverse so a stale sample cannot pass.
        o_miso = ~o_miso;
        if (cnt == 48)
        begin
            frames++;
            last_code = rx[47:32];
            if (rx[47:40] == 8'h01)
            begin
                gate_mem[rx[37:32]] = rx[31:16];
                dly_mem[rx[37:32]] = rx[15:0];
            end
            foreach (gate_mem[k])
            begin
                if (rx[47:32] == 16'h0500)
                begin
                    gate_mem[k] = rx[31:16];
                    dly_mem[k] = rx[15:0];
                end
                if (rx[47:32] == 16'h0300)
                    dly_mem[k] = 16'h0000;
            end
        end
    end
endmodule

// ===== tb/tb_gdc_controller.sv
// Self-checking bench for the gate and delay configuration controller.
`timescale 1ns/1ns
`include "gdc_defs.svh"
module tb_gdc_controller;
    // ----------------------------------------
    // Signals and instances
    // ----------------------------------------
    logic i_mclk, i_rst_n, i_ce, i_link_clk, i_nads, i_wnr, i_nblast;
    logic [15:0] i_lad, o_lad;
    logic o_lad_oe, o_nready, o_spi_sclk, o_spi_cs_n, o_spi_mosi, i_spi_miso;
    logic [31:0] i_user_pulses, o_user_delayed, o_delay_inputs, i_delay_outputs, rd;
    logic [15:0] adr [6] = '{16'h7F00, 16'h7F04, 16'h7F08, 16'h7F0C, 16'h7F10, 16'h7F14};
    logic [31:0] rv [6] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h1, 32'h0};
    int mismatches, total_checks;
    // The generator returns the pulses, so loop them straight back.
    assign i_delay_outputs = o_delay_inputs;
    gdc_controller dut (.i_mclk, .i_rst_n, .i_ce, .i_link_clk, .i_nads, .i_wnr, .i_nblast,
        .i_lad, .o_lad, .o_lad_oe, .o_nready, .i_user_pulses, .o_user_delayed, .o_delay_inputs,
        .i_delay_outputs, .o_spi_sclk, .o_spi_cs_n, .o_spi_mosi, .i_spi_miso);
    gdc_gen_model m (.i_sclk(o_spi_sclk), .i_cs_n(o_spi_cs_n), .i_mosi(o_spi_mosi),
        .o_miso(i_spi_miso));
    // Clocks: the link clock is offset so the two never line up.
    initial
    begin
        i_mclk = 1'b0;
        forever #4 i_mclk = ~i_mclk;
    end
    initial
    begin
        i_link_clk = 1'b0;
        #3;
        forever #40 i_link_clk = ~i_link_clk;
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic end_sim;
        if (mismatches == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Address cycle, then low and high halves; entered at a falling edge.
    task automatic lb_wr(input logic [15:0] a, input logic [31:0] d);
        i_nads = 1'b0;
        i_wnr = 1'b1;
        i_lad = a;
        @(negedge i_mclk);
        i_nads = 1'b1;
        i_lad = d[15:0];
        @(negedge i_mclk);
        i_lad = d[31:16];
        i_nblast = 1'b0;
        @(negedge i_mclk);
        i_nblast = 1'b1;
        chk("bus idle", {o_nready, o_lad_oe}, 32'h2);
    endtask
    task automatic lb_rd(input logic [15:0] a, output logic [31:0] d);
        i_nads = 1'b0;
        i_wnr = 1'b0;
        i_lad = a;
        @(negedge i_mclk);
        i_nads = 1'b1;
        i_lad = ~a;
        d[15:0] = o_lad;
        chk("bus ready", {o_nready, o_lad_oe}, 32'h1);
        @(negedge i_mclk);
        d[31:16] = o_lad;
        i_nblast = 1'b0;
        @(negedge i_mclk);
        i_nblast = 1'b1;
    endtask
    // Polls the ready flag with a bound; running out ends the run.
    task automatic wait_rdy;
        logic [31:0] s;
        for (int n = 0; n < 1000; n++)
        begin
            lb_rd(`GDC_A_STAT, s);
            if (s[0] === 1'b1)
                return;
        end
        mismatches++;
        end_sim;
    endtask
    // Command, control pulse, busy check, then control back to zero.
    task automatic run(input logic [31:0] code, input logic [31:0] ctl, input logic busy);
        lb_wr(`GDC_A_CMD, code);
        lb_wr(`GDC_A_CTRL, ctl);
        repeat (4) @(negedge i_mclk);
        lb_rd(`GDC_A_STAT, rd);
        chk("ready", rd, {31'h0, ~busy});
        wait_rdy;
        lb_wr(`GDC_A_CTRL, 32'h0);
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        mismatches = 0;
        total_checks = 0;
        i_rst_n = 1'b0;
        i_ce = 1'b1;
        i_nads = 1'b1;
        i_wnr = 1'b0;
        i_nblast = 1'b1;
        i_lad = 16'h0000;
        i_user_pulses = 32'h0000_0000;
        repeat (12) @(negedge i_mclk);
        i_rst_n = 1'b1;
        // Reset values, with one unmapped place at the end.
        for (int k = 0; k < 6; k++)
        begin
            lb_rd(adr[k], rd);
            chk("reset value", rd, rv[k]);
        end
        lb_wr(`GDC_A_WDAT, 32'h1234_ABCD);
        lb_rd(`GDC_A_WDAT, rd);
        chk("datum", rd, 32'h1234_ABCD);
        lb_wr(`GDC_A_CMD, 32'hFFFF_2000);
        lb_rd(`GDC_A_CMD, rd);
        chk("command", rd, 32'h0000_2000);
        lb_wr(`GDC_A_RDAT, 32'h5555_5555);
        lb_rd(`GDC_A_RDAT, rd);
        chk("read datum", rd, 32'h0);
        lb_wr(16'h1F00, 32'hFFFF_FFFF);
        lb_rd(16'h1F00, rd);
        chk("unmapped", rd, 32'h0);
        // Stage gate 5 and delay 8, then load channel 42.
        lb_wr(`GDC_A_WDAT, 32'h5);
        run(`GDC_C_GATE, 32'h1, 1'b0);
        lb_wr(`GDC_A_WDAT, 32'h8);
        run(`GDC_C_DELAY, 32'h1, 1'b0);
        chk("frames", 32'(m.frames), 32'h0);
        run(32'h0000_012A, 32'h1, 1'b1);
        chk("gate", m.gate_mem[42], 16'h5);
        chk("delay", m.dly_mem[42], 16'h8);
        chk("code", m.last_code, 16'h012A);
        // Read both values back.
        run(32'h0000_202A, 32'h2, 1'b1);
        lb_rd(`GDC_A_RDAT, rd);
        chk("read gate", rd, 32'hFFFA_0005);
        run(32'h0000_302A, 32'h2, 1'b1);
        lb_rd(`GDC_A_RDAT, rd);
        chk("read delay", rd, 32'hFFF7_0008);
        // Broadcast with channel bits set, then reset and calibrate.
        lb_wr(`GDC_A_WDAT, 32'h3);
        run(`GDC_C_GATE, 32'h1, 1'b0);
        run(32'h0000_053F, 32'h1, 1'b1);
        chk("bcast gate", m.gate_mem[31], 16'h3);
        chk("bcast delay", m.dly_mem[0], 16'h8);
        chk("bcast code", m.last_code, 16'h0500);
        run(`GDC_C_RESET, 32'h1, 1'b1);
        chk("reset delay", m.dly_mem[31], 16'h0);
        run(`GDC_C_CAL, 32'h1, 1'b1);
        chk("cal code", m.last_code, 16'h0400);
        // A second trigger while busy is dropped, so only one frame follows.
        lb_wr(`GDC_A_CMD, `GDC_C_RESET);
        lb_wr(`GDC_A_CTRL, 32'h1);
        lb_wr(`GDC_A_CTRL, 32'h0);
        lb_wr(`GDC_A_CTRL, 32'h1);
        wait_rdy;
        lb_wr(`GDC_A_CTRL, 32'h0);
        chk("busy trigger", 32'(m.frames), 32'h7);
        // With the enable low a write is not taken.
        i_ce = 1'b0;
        lb_wr(`GDC_A_WDAT, 32'hFFFF_FFFF);
        i_ce = 1'b1;
        lb_rd(`GDC_A_WDAT, rd);
        chk("frozen datum", rd, 32'h3);
        // User pulses go out and come back through the loop.
        i_user_pulses = 32'hDEAD_BEEF;
        repeat (4) @(negedge i_mclk);
        chk("to generator", o_delay_inputs, 32'hDEAD_BEEF);
        chk("from generator", o_user_delayed, 32'hDEAD_BEEF);
        end_sim;
    end
endmodule

// ===== verilog/gdc_controller.sv
// Gate and delay configuration controller with local bus registers.
`timescale 1ns/1ns
`include "gdc_defs.svh"
module gdc_controller
    import gdc_pkg::*;
(
    // Clocks, reset and enable.
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_link_clk,
    // Local bus slave.
    input wire logic i_nads,
    input wire logic i_wnr,
    input wire logic i_nblast,
    input wire logic [15:0] i_lad,
    output logic [15:0] o_lad,
    output logic o_lad_oe,
    output logic o_nready,
    // User logic pulses and their delayed returns.
    input wire logic [31:0] i_user_pulses,
    output logic [31:0] o_user_delayed,
    // Generator signal lines.
    output logic [31:0] o_delay_inputs,
    input wire logic [31:0] i_delay_outputs,
    // Generator SPI link.
    output logic o_spi_sclk,
    output logic o_spi_cs_n,
    output logic o_spi_mosi,
    input wire logic i_spi_miso
);
    //--------------------------------------------------
    // Declarations
    //--------------------------------------------------
    gdc_lb_t lb_st; // Local bus phase.
    logic [15:0] addr_reg; // Captured address.
    logic wr_reg; // Access is a write.
    logic [15:0] lo_reg; // Low half of a write.
    logic [31:0] rword_reg; // Word being read out.
    logic [31:0] wdat_reg; // Write datum.
    logic [15:0] cmd_reg; // Command code, reserved half dropped.
    logic [1:0] ctrl_reg; // Action bits.
    logic [1:0] ctrl_prev_reg; // Action bits one cycle ago.
    logic [31:0] rdat_reg; // Read datum.
    logic ready_reg; // Ready flag.
    logic ovf_reg; // Staged sum too large.
    logic [15:0] gate_reg; // Staged gate value.
    logic [15:0] delay_reg; // Staged delay value.
    logic [`GDC_FR_W-1:0] frame_reg; // Frame handed to the link.
    logic req_tgl_reg; // Request toggle to the link.
    logic ack_seen_reg; // Last ack toggle handled.
    logic op_rd_reg; // Running action is a read.
    logic lb_wr; // Register write strobe.
    logic [31:0] lb_wdata; // Assembled write word.
    logic in_win; // Address inside the controller window.
    logic trig_wr; // Write bit rose.
    logic trig_rd; // Read bit rose.
    logic go_write; // Write action accepted.
    logic go_read; // Read action accepted.
    logic [15:0] base; // Code with channel bits cleared.
    logic spi_w; // Write action needing SPI.
    logic spi_r; // Read action needing SPI.
    logic launch; // Frame sent this cycle.
    logic ack_evt; // Link finished a frame.
    logic ack_s; // Synchronised ack toggle.
    logic [`GDC_RX_W-1:0] rx_word; // Word captured by the link.
    logic [2:0] link_s; // Enable, request and MISO on link clock.
    logic ce_link; // Enable on link clock.
    logic link_ack_tgl; // Ack toggle on link clock.

    //--------------------------------------------------
    // Functions
    //--------------------------------------------------
    // Register read map; unmapped addresses read zero.
    function automatic logic [31:0] rd_mux(input logic [15:0] a);
        logic [31:0] v;
        v = `GDC_R32;
        if (a == `GDC_A_WDAT)
            v = wdat_reg;
        else if (a == `GDC_A_CMD)
            v = {16'h0000, cmd_reg};
        else if (a == `GDC_A_CTRL)
            v = {30'h0000_0000, ctrl_reg};
        else if (a == `GDC_A_RDAT)
            v = rdat_reg;
        else if (a == `GDC_A_STAT)
            v = {30'h0000_0000, ovf_reg, ready_reg};
        return v;
    endfunction

    // Trailing edge step count: delay plus gate.
    function automatic logic [16:0] trail_steps(input logic [15:0] g,
                                                input logic [15:0] d);
        return 17'({1'b0, g} + {1'b0, d});
    endfunction

    //--------------------------------------------------
    // Local bus slave
    //--------------------------------------------------
    // window decode.
    assign in_win = (addr_reg[15:8] == `GDC_WIN_PAGE);
    assign lb_wr = i_ce && (lb_st == LB_HI) && wr_reg && in_win;
    assign lb_wdata = {i_lad, lo_reg};

    // One address cycle, then low and high data halves. Ready is held low
    // over both halves so each data phase completes in one cycle.
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            lb_st <= LB_IDLE;
            addr_reg <= `GDC_R16;
            wr_reg <= 1'b0;
            lo_reg <= `GDC_R16;
            rword_reg <= `GDC_R32;
            o_lad <= `GDC_R16;
            o_lad_oe <= 1'b0;
            o_nready <= 1'b1;
        end
        else if (i_ce)
        begin
            case (lb_st)
                LB_IDLE:
                begin
                    if (!i_nads)
                    begin
                        addr_reg <= i_lad;
                        wr_reg <= i_wnr;
                        rword_reg <= rd_mux(i_lad);
                        o_lad <= 16'(rd_mux(i_lad) & {16{~i_wnr}});
                        o_lad_oe <= ~i_wnr;
                        o_nready <= 1'b0;
                        lb_st <= LB_LO;
                    end
                end
                LB_LO:
                begin
                    lo_reg <= i_lad;
                    o_lad <= rword_reg[31:16];
                    lb_st <= LB_HI;
                end
                default:
                begin
                    // The second half always ends the access.
                    o_lad_oe <= 1'b0;
                    o_nready <= 1'b1;
                    lb_st <= LB_IDLE;
                end
            endcase
        end
    end

    //--------------------------------------------------
    // Software registers
    //--------------------------------------------------
    // Reserved bits are not stored, so they read back as zero.
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            wdat_reg <= `GDC_R32;
            cmd_reg <= `GDC_R16;
            ctrl_reg <= `GDC_R2;
        end
        else if (lb_wr)
        begin
            if (addr_reg == `GDC_A_WDAT)
                wdat_reg <= lb_wdata;
            else if (addr_reg == `GDC_A_CMD)
                cmd_reg <= lb_wdata[15:0];
            else if (addr_reg == `GDC_A_CTRL)
                ctrl_reg <= lb_wdata[`GDC_CTL_W-1:0];
        end
    end

    //--------------------------------------------------
    // Command interpreter
    //--------------------------------------------------
    // edge detect on action bits.
    assign trig_wr = ctrl_reg[`GDC_CTL_WR] && !ctrl_prev_reg[`GDC_CTL_WR];
    assign trig_rd = ctrl_reg[`GDC_CTL_RD] && !ctrl_prev_reg[`GDC_CTL_RD];
    // table chosen by action bit; write wins a tie.
    assign go_write = i_ce && ready_reg && trig_wr;
    assign go_read = i_ce && ready_reg && trig_rd && !trig_wr;
    assign base = {cmd_reg[15:`GDC_CH_W], `GDC_CH_ZERO};
    assign spi_w = go_write && (base == `GDC_C_LOAD || base == `GDC_C_RESET
                   || base == `GDC_C_CAL || base == `GDC_C_BCAST);
    assign spi_r = go_read && (base == `GDC_C_GATE || base == `GDC_C_DELAY);
    assign launch = spi_w || spi_r;
    assign ack_evt = i_ce && (ack_s != ack_seen_reg);

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            ctrl_prev_reg <= `GDC_R2;
        else if (i_ce)
            ctrl_prev_reg <= ctrl_reg;
    end

    // Staged values change only when no frame is in flight.
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            gate_reg <= `GDC_R16;
            delay_reg <= `GDC_R16;
            ovf_reg <= 1'b0;
        end
        else if (i_ce)
        begin
            if (go_write && base == `GDC_C_GATE)
                gate_reg <= wdat_reg[15:0];
            else if (go_write && base == `GDC_C_DELAY)
                delay_reg <= wdat_reg[15:0];
            // flag when trail steps exceed the range.
            ovf_reg <= (trail_steps(gate_reg, delay_reg) > `GDC_VAL_MAX);
        end
    end

    // Frame build and ready handshake. The frame stays still until the
    // ack, which lets the link side read it across the clock boundary.
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            frame_reg <= '0;
            req_tgl_reg <= 1'b0;
            ready_reg <= 1'b1;
            op_rd_reg <= 1'b0;
            ack_seen_reg <= 1'b0;
            rdat_reg <= `GDC_R32;
        end
        else if (i_ce)
        begin
            if (launch)
            begin
                // code, gate and delay in one frame.
                frame_reg <= {spi_w && base != `GDC_C_LOAD ? base : cmd_reg,
                              spi_r ? `GDC_R16 : gate_reg,
                              spi_r ? `GDC_R16 : delay_reg};
                req_tgl_reg <= ~req_tgl_reg;
                op_rd_reg <= spi_r;
                ready_reg <= 1'b0;
            end
            else if (ack_evt)
            begin
                ack_seen_reg <= ack_s;
                ready_reg <= 1'b1;
                if (op_rd_reg)
                    rdat_reg <= rx_word;
            end
        end
    end

    //--------------------------------------------------
    // Generator lines and link
    //--------------------------------------------------
    // user pulses to the generator.
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_delay_inputs <= `GDC_R32;
        else if (i_ce)
            o_delay_inputs <= i_user_pulses;
    end

    // returns pass unchanged; 32 generator lines plus the ack toggle.
    gdc_sync #(.W(33)) u_sync_m (
        .i_clk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_ce(i_ce),
        .i_d({link_ack_tgl, i_delay_outputs}),
        .o_q({ack_s, o_user_delayed})
    );

    // Enable, request toggle and MISO enter the link domain.
    gdc_sync #(.W(3)) u_sync_l (
        .i_clk(i_link_clk),
        .i_rst_n(i_rst_n),
        .i_ce(1'b1),
        .i_d({i_ce, req_tgl_reg, i_spi_miso}),
        .o_q(link_s)
    );
    assign ce_link = link_s[2];

    gdc_spi_engine u_spi (
        .i_link_clk(i_link_clk),
        .i_rst_n(i_rst_n),
        .i_ce(ce_link),
        .i_req_tgl(link_s[1]),
        .i_frame(frame_reg),
        .i_miso(link_s[0]),
        .o_sclk(o_spi_sclk),
        .o_cs_n(o_spi_cs_n),
        .o_mosi(o_spi_mosi),
        .o_ack_tgl(link_ack_tgl),
        .o_rx(rx_word)
    );

    //--------------------------------------------------
    // Checks
    //--------------------------------------------------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);

    a_ready_drop:
    assert property (launch |=> !ready_reg)
        else $error("ready stayed high after an accepted action");

    a_stage_gate:
    assert property (go_write && base == `GDC_C_GATE
                     |=> gate_reg == $past(wdat_reg[15:0]) && ready_reg
                         && $stable(req_tgl_reg))
        else $error("gate staging wrong or sent a frame");

    a_stage_delay:
    assert property (go_write && base == `GDC_C_DELAY
                     |=> delay_reg == $past(wdat_reg[15:0]))
        else $error("delay staging wrong");

    a_ready_back:
    assert property (ack_evt && !ready_reg |=> ready_reg)
        else $error("ready did not return after the frame");

    a_rdat_load:
    assert property (ack_evt && op_rd_reg |=> rdat_reg == $past(rx_word))
        else $error("read datum not loaded");

    a_chan_field:
    assert property (spi_w && base == `GDC_C_LOAD
                     |=> frame_reg[`GDC_FR_CODE +: `GDC_CH_W]
                         == $past(cmd_reg[`GDC_CH_W-1:0]))
        else $error("channel field lost in load frame");

    a_bcast_both:
    assert property (spi_w && base == `GDC_C_BCAST
                     |=> frame_reg[`GDC_FR_CODE +: `GDC_CH_W] == `GDC_CH_ZERO
                         && frame_reg[`GDC_FR_GATE +: `GDC_VAL_W] == $past(gate_reg)
                         && frame_reg[`GDC_FR_DLY +: `GDC_VAL_W] == $past(delay_reg))
        else $error("broadcast frame fields wrong");

    a_busy_ignore:
    assert property (i_ce && !ready_reg && !ack_evt && (trig_wr || trig_rd)
                     |=> !ready_reg && $stable(frame_reg))
        else $error("trigger accepted while busy");

    a_nready_phase:
    assert property (i_ce && lb_st == LB_IDLE && !i_nads
                     |=> !o_nready && o_lad_oe == !$past(i_wnr))
        else $error("bus slave did not answer the address phase");
endmodule

// ===== verilog/gdc_defs.svh
// Constants for the gate and delay configuration controller.
// How it works
// - Pass 32 user pulses to the generator.
// - Output width set by gate value alone.
// - Edges counted in steps, trail uses sum.
// - Registers sit in the 0x7F00 window.
// - Write datum register stages a value.
// - Codes 0x2000/0x3000 stage gate/delay, no SPI.
// - Code 0x0100 plus channel loads one channel.
// - Codes 0x0300 reset, 0x0400 calibrate all delays.
// - Code 0x0500 broadcasts, channel bits ignored.
// - Broadcast sends gate and delay together.
// - Read codes 0x2000/0x3000 fetch one channel.
// - Channel is command bits five to zero.
// - Control action bit selects code table.
// - Control bit1 reads, bit0 writes.
// - Read datum shows the returned value.
// - Status bit0 low while busy.
// - Generator joined by 32+32 lines and SPI.
`ifndef GDC_DEFS_SVH
`define GDC_DEFS_SVH
// Register addresses on the local bus.
`define GDC_WIN_PAGE 8'h7F
`define GDC_A_WDAT 16'h7F00
`define GDC_A_CMD 16'h7F04
`define GDC_A_CTRL 16'h7F08
`define GDC_A_RDAT 16'h7F0C
`define GDC_A_STAT 16'h7F10
// Command codes, channel bits cleared.
`define GDC_C_GATE 16'h2000
`define GDC_C_DELAY 16'h3000
`define GDC_C_LOAD 16'h0100
`define GDC_C_RESET 16'h0300
`define GDC_C_CAL 16'h0400
`define GDC_C_BCAST 16'h0500
`define GDC_CH_W 6
`define GDC_CH_ZERO 6'h00
// Control bit positions and width.
`define GDC_CTL_WR 0
`define GDC_CTL_RD 1
`define GDC_CTL_W 2
// Value width, limit and reset values.
`define GDC_VAL_W 16
`define GDC_VAL_MAX 17'h0_FFFF
`define GDC_R32 32'h0000_0000
`define GDC_R16 16'h0000
`define GDC_R2 2'h0
// Generator step times, typical figures.
`define GDC_T0_NS 12.0
`define GDC_T1_NS 10.7
// SPI frame layout and timing.
`define GDC_FR_W 48
`define GDC_FR_CODE 32
`define GDC_FR_GATE 16
`define GDC_FR_DLY 0
`define GDC_RX_W 32
`define GDC_FR_LAST 6'h2F
`define GDC_CNT_R 6'h00
`define GDC_PH_RISE 2'h1
`define GDC_PH_LAST 2'h3
`define GDC_PH_R 2'h0
`endif

// ===== verilog/gdc_pkg.sv
// Types shared by the gate and delay controller modules.
package gdc_pkg;
    // Local bus slave phases.
    typedef enum logic [1:0] {LB_IDLE, LB_LO, LB_HI} gdc_lb_t;
    // SPI engine states.
    typedef enum logic [1:0] {SP_IDLE, SP_SHIFT, SP_END} gdc_spi_t;
endpackage

// ===== verilog/gdc_spi_engine.sv
// SPI master shifter running on the link clock.
`timescale 1ns/1ns
`include "gdc_defs.svh"
module gdc_spi_engine
    import gdc_pkg::*;
(
    // Link clock, reset and synchronised enable.
    input wire logic i_link_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    // Request toggle and frame from the register side.
    input wire logic i_req_tgl,
    input wire logic [`GDC_FR_W-1:0] i_frame,
    // Synchronised slave output line.
    input wire logic i_miso,
    // SPI pins.
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_mosi,
    // Completion toggle and captured word.
    output logic o_ack_tgl,
    output logic [`GDC_RX_W-1:0] o_rx
);
    gdc_spi_t st_reg; // Engine state.
    logic req_seen_reg; // Last request toggle served.
    logic [`GDC_FR_W-1:0] sh_reg; // Outgoing shift register.
    logic [5:0] cnt_reg; // Bit index within the frame.
    logic [1:0] ph_reg; // Quarter of the current bit.

    // Each bit takes four link cycles: clock low for two, high for two.
    // The frame is held stable by the register side until the ack, so it
    // may be sampled here without its own synchroniser.
    always_ff @(posedge i_link_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            st_reg <= SP_IDLE;
            req_seen_reg <= 1'b0;
            sh_reg <= '0;
            cnt_reg <= `GDC_CNT_R;
            ph_reg <= `GDC_PH_R;
            o_sclk <= 1'b0;
            o_cs_n <= 1'b1;
            o_mosi <= 1'b0;
            o_ack_tgl <= 1'b0;
            o_rx <= `GDC_R32;
        end
        else if (i_ce)
        begin
            case (st_reg)
                SP_IDLE:
                begin
                    if (i_req_tgl != req_seen_reg)
                    begin
                        req_seen_reg <= i_req_tgl;
                        sh_reg <= i_frame;
                        o_mosi <= i_frame[`GDC_FR_W-1];
                        cnt_reg <= `GDC_CNT_R;
                        ph_reg <= `GDC_PH_R;
                        o_cs_n <= 1'b0;
                        st_reg <= SP_SHIFT;
                    end
                end
                SP_SHIFT:
                begin
                    ph_reg <= 2'(ph_reg + 2'h1);
                    if (ph_reg == `GDC_PH_RISE)
                    begin
                        o_sclk <= 1'b1;
                    end
                    else if (ph_reg == `GDC_PH_LAST)
                    begin
                        o_sclk <= 1'b0;
                        o_rx <= {o_rx[`GDC_RX_W-2:0], i_miso};
                        sh_reg <= {sh_reg[`GDC_FR_W-2:0], 1'b0};
                        o_mosi <= sh_reg[`GDC_FR_W-2];
                        cnt_reg <= 6'(cnt_reg + 6'h01);
                        if (cnt_reg == `GDC_FR_LAST)
                        begin
                            st_reg <= SP_END;
                        end
                    end
                end
                default:
                begin
                    // Release select and report completion in the same cycle.
                    o_cs_n <= 1'b1;
                    o_mosi <= 1'b0;
                    o_ack_tgl <= ~o_ack_tgl;
                    st_reg <= SP_IDLE;
                end
            endcase
        end
    end
endmodule

// ===== verilog/gdc_sync.sv
// Two flip-flop synchroniser for a group of level signals.
`timescale 1ns/1ns
`include "gdc_defs.svh"
module gdc_sync #(
    parameter int W = 1
) (
    // Clock, reset and enable.
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    // Asynchronous data in, synchronised data out.
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    // First stage; only the second stage reads it.
    logic [W-1:0] meta_reg;

    // The pair shifts together so both stages hold while enable is low.
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            meta_reg <= '0;
            o_q <= '0;
        end
        else if (i_ce)
        begin
            meta_reg <= i_d;
            o_q <= meta_reg;
        end
    end
endmodule
